// >>> hw/amtt_alert_ctrl.sv
// amtt_alert_ctrl: sticky status, alert masking and routing, thermal assertion timer.
// assumes out-of-limit flags come from measurement logic on clk_in, the thermal input is an
// asynchronous active-low pin, and software uses an AXI4-Lite master.
`timescale 1ns/1ns

module amtt_alert_ctrl #(
  parameter int TIMER_TICK_CYCLES = amtt_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic                          clk_in,
  input  wire logic                          arst_n_in,
  // axi4-lite write address and data
  input  wire logic                          awvalid_in,
  output logic                               awready_out,
  input  wire logic [amtt_pkg::ADDR_W-1:0]   awaddr_in,
  input  wire logic [2:0]                    awprot_in,
  input  wire logic                          wvalid_in,
  output logic                               wready_out,
  input  wire logic [amtt_pkg::DATA_W-1:0]   wdata_in,
  input  wire logic [3:0]                    wstrb_in,
  // axi4-lite write response
  output logic                               bvalid_out,
  input  wire logic                          bready_in,
  output logic [1:0]                         bresp_out,
  // axi4-lite read
  input  wire logic                          arvalid_in,
  output logic                               arready_out,
  input  wire logic [amtt_pkg::ADDR_W-1:0]   araddr_in,
  input  wire logic [2:0]                    arprot_in,
  output logic                               rvalid_out,
  input  wire logic                          rready_in,
  output logic [amtt_pkg::DATA_W-1:0]        rdata_out,
  output logic [1:0]                         rresp_out,
  // out-of-limit flags from measurement logic, same clock
  input  wire logic [6:0]                    ool_one_in,
  input  wire logic [7:0]                    ool_two_in,
  // thermal event pin, active low, asynchronous
  input  wire logic                          cpu_hot_signal_n_in,
  // alert pins, open drain: pin is pulled low while its enable is high
  output logic                               alert_pin_one_oe_out,
  output logic                               alert_on_second_pin_oe_out,
  // fan override
  output logic                               fan_full_duty_out
);
  import amtt_pkg::*;

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TIMER_TICK_CYCLES - 1);

  typedef struct packed {
    logic              aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic              awready;
    logic              w_full;
    logic [7:0]        w_data;
    logic              w_lane0;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [7:0]        rdata;
    logic [1:0]        rresp;
    logic [7:0]        mask_one;
    logic [7:0]        mask_two;
    logic [7:0]        config_three;
    logic [7:0]        config_four;
    logic [7:0]        limit;
    logic [7:0]        timer;
    logic [6:0]        stat_one;
    logic [7:0]        stat_two;
    logic [TICK_W-1:0] sub;
    logic              past_first;
    logic              hot_meta;
    logic              hot_sync_n;
    logic              alert_one_oe;
    logic              alert_two_oe;
    logic              fan_full;
  } amtt_state_s;

  amtt_state_s st_r;
  amtt_state_s st_nxt;

  logic       rd_take;
  logic       rd_ok;
  logic [7:0] rd_idx;
  logic       wr_do;
  logic       wr_ok;
  logic [7:0] wr_idx;
  logic       therm_on;
  logic       tick;
  logic [6:0] cond_one;
  logic [7:0] cond_two;
  logic       alert_act;

  // byte address to register index
  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] addr);
    return addr[9:2];
  endfunction

  // unaligned or unlisted addresses answer with slverr
  function automatic logic reg_mapped(input logic [ADDR_W-1:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    if (addr[1:0] != 2'h0 || addr[ADDR_W-1:10] != '0) begin
      return 1'b0;
    end
    case (idx)
      IDX_STATUS_ONE, IDX_STATUS_TWO, IDX_MASK_ONE, IDX_MASK_TWO,
      IDX_CONFIG_3, IDX_TIMER, IDX_LIMIT, IDX_CONFIG_4: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  always_comb begin
    st_nxt   = st_r;
    rd_take  = arvalid_in && st_r.arready;
    rd_ok    = reg_mapped(araddr_in);
    rd_idx   = reg_index(araddr_in);
    wr_do    = st_r.aw_full && st_r.w_full && !st_r.bvalid;
    wr_ok    = reg_mapped(st_r.aw_addr);
    wr_idx   = reg_index(st_r.aw_addr);
    tick     = st_r.sub == TICK_LAST;

    // pin passes two flops before anything looks at it
    st_nxt.hot_meta   = cpu_hot_signal_n_in;
    st_nxt.hot_sync_n = st_r.hot_meta;
    therm_on = st_r.config_three[C3_THERM_EN] && !st_r.hot_sync_n;

    // write channel: address and data taken in either order
    if (awvalid_in && st_r.awready) begin
      st_nxt.aw_full = 1'b1;
      st_nxt.aw_addr = awaddr_in;
    end
    if (wvalid_in && st_r.wready) begin
      st_nxt.w_full  = 1'b1;
      st_nxt.w_data  = wdata_in[7:0];
      st_nxt.w_lane0 = wstrb_in[0];
    end
    if (st_r.bvalid && bready_in) begin
      st_nxt.bvalid = 1'b0;
    end
    if (wr_do) begin
      st_nxt.aw_full = 1'b0;
      st_nxt.w_full  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
      // status and timer are read-only; writes there are accepted and dropped
      if (wr_ok && st_r.w_lane0) begin
        case (wr_idx)
          IDX_MASK_ONE: st_nxt.mask_one     = st_r.w_data & MASK_ONE_WR;
          IDX_MASK_TWO: st_nxt.mask_two     = st_r.w_data & MASK_TWO_WR;
          IDX_CONFIG_3: st_nxt.config_three = st_r.w_data & CONFIG_3_WR;
          IDX_CONFIG_4: st_nxt.config_four  = st_r.w_data & CONFIG_4_WR;
          IDX_LIMIT:    st_nxt.limit        = st_r.w_data;
          default:      st_nxt.limit        = st_r.limit;
        endcase
      end
    end
    st_nxt.awready = !st_nxt.aw_full;
    st_nxt.wready  = !st_nxt.w_full;

    // thermal timer: accumulates over assertions, never restarts on its own
    if (therm_on) begin
      if (st_r.timer == TIMER_CLEAR) begin
        st_nxt.timer = TIMER_FIRST;
      end
      if (tick) begin
        st_nxt.sub = '0;
        // the first step holds the value at one until two lsb periods have passed
        if (!st_r.past_first) begin
          st_nxt.past_first = 1'b1;
        end else if (st_r.timer != TIMER_FULL) begin
          st_nxt.timer = st_r.timer + 8'h01;
        end
      end else begin
        st_nxt.sub = st_r.sub + TICK_W'(1);
      end
    end

    // bit 5 of status two follows the timer comparison in thermal mode
    cond_one = ool_one_in & STAT_ONE_USED;
    cond_two = ool_two_in & STAT_TWO_USED;
    if (st_r.config_three[C3_THERM_EN]) begin
      cond_two[S2_FOURTH_FAN_FAIL_TIMER] = st_r.timer > st_r.limit;
    end

    // sticky flags; on a read a still-present fault keeps its flag set
    st_nxt.stat_one = st_r.stat_one | cond_one;
    st_nxt.stat_two = st_r.stat_two | cond_two;

    // read channel and its side effects
    if (st_r.rvalid && rready_in) begin
      st_nxt.rvalid = 1'b0;
    end
    if (rd_take) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
      st_nxt.rdata  = 8'h00;
      if (rd_ok) begin
        case (rd_idx)
          IDX_STATUS_ONE: begin
            st_nxt.rdata    = {|st_r.stat_two, st_r.stat_one};
            st_nxt.stat_one = cond_one;
          end
          IDX_STATUS_TWO: begin
            st_nxt.rdata    = st_r.stat_two;
            st_nxt.stat_two = cond_two;
          end
          IDX_MASK_ONE: st_nxt.rdata = st_r.mask_one;
          IDX_MASK_TWO: st_nxt.rdata = st_r.mask_two;
          IDX_CONFIG_3: st_nxt.rdata = st_r.config_three;
          IDX_CONFIG_4: st_nxt.rdata = st_r.config_four;
          IDX_LIMIT:    st_nxt.rdata = st_r.limit;
          IDX_TIMER: begin
            // clear on read; an assertion in progress restarts at one
            st_nxt.rdata      = st_r.timer;
            st_nxt.timer      = therm_on ? TIMER_FIRST : TIMER_CLEAR;
            st_nxt.sub        = '0;
            st_nxt.past_first = 1'b0;
          end
          default: st_nxt.rdata = 8'h00;
        endcase
      end
    end
    st_nxt.arready = !st_nxt.rvalid;

    // alert from flags as they stand after this cycle, so a read releases it at once
    alert_act = |(st_nxt.stat_one & ~st_r.mask_one[6:0])
              | ((|(st_nxt.stat_two & ~st_r.mask_two)) & !st_r.mask_one[M1_SUMMARY]);
    st_nxt.alert_one_oe = st_r.config_three[C3_ALERT_PIN1] && alert_act;
    st_nxt.alert_two_oe = st_r.config_four[C4_ALERT_PIN2] && alert_act;
    st_nxt.fan_full     = st_r.config_three[C3_FAN_BOOST] && therm_on;
  end

  // reset clears the alert enables, so no pin drives until configured
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign awready_out                = st_r.awready;
  assign wready_out                 = st_r.wready;
  assign bvalid_out                 = st_r.bvalid;
  assign bresp_out                  = st_r.bresp;
  assign arready_out                = st_r.arready;
  assign rvalid_out                 = st_r.rvalid;
  assign rdata_out                  = {24'h000000, st_r.rdata};
  assign rresp_out                  = st_r.rresp;
  assign alert_pin_one_oe_out       = st_r.alert_one_oe;
  assign alert_on_second_pin_oe_out = st_r.alert_two_oe;
  assign fan_full_duty_out          = st_r.fan_full;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  logic rd_stat_one;
  logic rd_timer;
  assign rd_stat_one = rd_take && rd_ok && rd_idx == IDX_STATUS_ONE;
  assign rd_timer    = rd_take && rd_ok && rd_idx == IDX_TIMER;

  sticky_hold_a: assert property (
    st_r.stat_one[4] && !rd_stat_one |=> st_r.stat_one[4])
    else $error("status flag dropped without a read");
  alert_holds_a: assert property (
    st_r.stat_one[6] && !st_r.mask_one[6] && st_r.config_three[0] && !rd_stat_one
      |=> alert_pin_one_oe_out)
    else $error("alert released while unmasked flag set");
  masked_sets_a: assert property (
    ool_one_in[6] && st_r.mask_one[6] |=> st_r.stat_one[6])
    else $error("masked source did not set its flag");
  mask_all_a: assert property (
    st_r.mask_one == MASK_ONE_WR && st_r.mask_two == MASK_TWO_WR |=> !alert_pin_one_oe_out)
    else $error("alert with every source masked");
  pin_one_off_a: assert property (
    !st_r.config_three[0] |=> !alert_pin_one_oe_out)
    else $error("first pin drives while not enabled");
  pin_two_off_a: assert property (
    !st_r.config_four[0] |=> !alert_on_second_pin_oe_out)
    else $error("second pin drives while not enabled");
  timer_sat_a: assert property (
    st_r.timer == TIMER_FULL && !rd_timer |=> st_r.timer == TIMER_FULL)
    else $error("timer left full scale without a read");
  first_assert_a: assert property (
    therm_on && st_r.timer == TIMER_CLEAR && !rd_timer |=> st_r.timer == TIMER_FIRST)
    else $error("timer bit 0 not set on first assertion");
  read_restart_a: assert property (
    rd_timer && therm_on |=> st_r.timer == TIMER_FIRST && st_r.sub == '0)
    else $error("read during assertion did not restart timer");
  limit_flag_a: assert property (
    st_r.config_three[1] && st_r.timer > st_r.limit |=> st_r.stat_two[5])
    else $error("timer above limit did not set flag");
  fan_boost_a: assert property (
    st_r.config_three[2] && therm_on |=> fan_full_duty_out)
    else $error("fans not forced while thermal input asserted");
endmodule // amtt_alert_ctrl

// >>> hw/amtt_pkg.sv
// amtt_pkg: register map, field positions and timing for the alert mask and thermal timer.
// assumes a 50 MHz system clock and an AXI4-Lite master with 32-bit data.
package amtt_pkg;
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 32;
  // register indices; the byte address is four times the index
  localparam logic [7:0]  IDX_STATUS_ONE = 8'h41;
  localparam logic [7:0]  IDX_STATUS_TWO = 8'h42;
  localparam logic [7:0]  IDX_MASK_ONE   = 8'h74;
  localparam logic [7:0]  IDX_MASK_TWO   = 8'h75;
  localparam logic [7:0]  IDX_CONFIG_3   = 8'h78;
  localparam logic [7:0]  IDX_TIMER      = 8'h79;
  localparam logic [7:0]  IDX_LIMIT      = 8'h7A;
  localparam logic [7:0]  IDX_CONFIG_4   = 8'h7D;
  // reset values
  localparam logic [7:0]  RST_MASK       = 8'h00;
  localparam logic [7:0]  RST_CONFIG     = 8'h00;
  localparam logic [7:0]  RST_LIMIT      = 8'h00;
  // writable bits of each mask and config register; unused bits read as zero
  localparam logic [7:0]  MASK_ONE_WR    = 8'hF5;
  localparam logic [7:0]  MASK_TWO_WR    = 8'hFE;
  localparam logic [7:0]  CONFIG_3_WR    = 8'h07;
  localparam logic [7:0]  CONFIG_4_WR    = 8'h01;
  // status bits that exist
  localparam logic [6:0]  STAT_ONE_USED  = 7'h75;
  localparam logic [7:0]  STAT_TWO_USED  = 8'hFE;
  // field positions
  localparam int          M1_SUMMARY     = 7;
  localparam int          S2_FOURTH_FAN_FAIL_TIMER  = 5;
  localparam int          C3_ALERT_PIN1  = 0;
  localparam int          C3_THERM_EN    = 1;
  localparam int          C3_FAN_BOOST   = 2;
  localparam int          C4_ALERT_PIN2  = 0;
  // timer values
  localparam logic [7:0]  TIMER_CLEAR    = 8'h00;
  localparam logic [7:0]  TIMER_FIRST    = 8'h01;
  localparam logic [7:0]  TIMER_FULL     = 8'hFF;
  // timing
  localparam int          CLK_PERIOD_NS  = 20;
  localparam int          THERM_LSB_NS   = 22_760_000;
  localparam int          THERM_STEP_NS  = 45_520_000;
  localparam int          STEP_TICKS     = THERM_STEP_NS / THERM_LSB_NS;
  localparam int          TICK_CYCLES    = THERM_LSB_NS / CLK_PERIOD_NS;
  localparam int          TICK_W         = 21;
  // bus responses
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage

// >>> verif/amtt_host_model.sv
// amtt_host_model: axi4-lite master standing in for host software.
// assumes one bus task is called at a time, from a single process.
`timescale 1ns/1ns
module amtt_host_model (
  // clock
  input  wire logic        clk_in,
  // write channels
  output logic             awvalid_out,
  input  wire logic        awready_in,
  output logic [11:0]      awaddr_out,
  output logic             wvalid_out,
  input  wire logic        wready_in,
  output logic [31:0]      wdata_out,
  input  wire logic        bvalid_in,
  output logic             bready_out,
  input  wire logic [1:0]  bresp_in,
  // read channels
  output logic             arvalid_out,
  input  wire logic        arready_in,
  output logic [11:0]      araddr_out,
  input  wire logic        rvalid_in,
  output logic             rready_out,
  input  wire logic [31:0] rdata_in,
  input  wire logic [1:0]  rresp_in
);
  initial begin
    {awvalid_out, wvalid_out, bready_out, arvalid_out, rready_out} = '0;
    {awaddr_out, araddr_out, wdata_out} = '0;
  end

  // no wait limit here: a stuck slave is cut short by the bench timeout
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clk_in);
    awvalid_out <= 1'b1;
    awaddr_out  <= a;
    wvalid_out  <= 1'b1;
    wdata_out   <= d;
    bready_out  <= 1'b1;
    while (!done) begin
      @(posedge clk_in);
      if (awvalid_out && awready_in) begin
        awvalid_out <= 1'b0;
      end
      if (wvalid_out && wready_in) begin
        wvalid_out <= 1'b0;
      end
      if (bvalid_in) begin
        r    = bresp_in;
        done = 1'b1;
      end
    end
    bready_out <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clk_in);
    arvalid_out <= 1'b1;
    araddr_out  <= a;
    rready_out  <= 1'b1;
    while (!done) begin
      @(posedge clk_in);
      if (arvalid_out && arready_in) begin
        arvalid_out <= 1'b0;
      end
      if (rvalid_in) begin
        d    = rdata_in;
        r    = rresp_in;
        done = 1'b1;
      end
    end
    rready_out <= 1'b0;
  endtask
endmodule // amtt_host_model

// >>> verif/alert_mask_and_thermal_timer_bench.sv
// alert_mask_and_thermal_timer_bench: directed tests of alert masking and thermal timer.
// assumes the host model drives the bus; timer tick shortened to 8 cycles.
`timescale 1ns/1ns
module alert_mask_and_thermal_timer_bench;
  import amtt_pkg::*;
  logic        clk_in, arst_n_in, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, hot_n, oe_one, oe_two, fan_full;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [6:0]  ool_one;
  logic [7:0]  ool_two;
  int          fails = 0;
  int          n_checks = 0;
  int          cycles = 0;

  amtt_alert_ctrl #(.TIMER_TICK_CYCLES(8)) u_dut (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .awvalid_in(awvalid), .awready_out(awready),
    .awaddr_in(awaddr), .awprot_in(3'h0), .wvalid_in(wvalid), .wready_out(wready),
    .wdata_in(wdata), .wstrb_in(4'hF), .bvalid_out(bvalid), .bready_in(bready),
    .bresp_out(bresp), .arvalid_in(arvalid), .arready_out(arready), .araddr_in(araddr),
    .arprot_in(3'h0), .rvalid_out(rvalid), .rready_in(rready), .rdata_out(rdata),
    .rresp_out(rresp), .ool_one_in(ool_one), .ool_two_in(ool_two),
    .cpu_hot_signal_n_in(hot_n), .alert_pin_one_oe_out(oe_one),
    .alert_on_second_pin_oe_out(oe_two), .fan_full_duty_out(fan_full));

  amtt_host_model u_host (
    .clk_in(clk_in), .awvalid_out(awvalid), .awready_in(awready), .awaddr_out(awaddr),
    .wvalid_out(wvalid), .wready_in(wready), .wdata_out(wdata), .bvalid_in(bvalid),
    .bready_out(bready), .bresp_in(bresp), .arvalid_out(arvalid), .arready_in(arready),
    .araddr_out(araddr), .rvalid_in(rvalid), .rready_out(rready), .rdata_in(rdata),
    .rresp_in(rresp));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // the whole run needs about 2500 cycles
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [11:0] ba(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic w(input logic [7:0] i, input logic [7:0] d);
    logic [1:0] r;
    u_host.wr(ba(i), {24'h0, d}, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  task automatic rc(input logic [7:0] i, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    u_host.rd(ba(i), d, r);
    chk(d, {24'h0, e});
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    chk({oe_one, oe_two}, 0);
    rc(IDX_MASK_ONE, 0);
    rc(IDX_CONFIG_3, 0);
    rc(IDX_CONFIG_4, 0);
    w(IDX_MASK_ONE, 8'hFF);
    rc(IDX_MASK_ONE, 8'hF5);
    w(IDX_MASK_TWO, 8'hFF);
    rc(IDX_MASK_TWO, 8'hFE);
    w(IDX_MASK_ONE, 0);
    w(IDX_MASK_TWO, 0);
    u_host.rd(12'hFFC, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    $display("test regs done");
  endtask

  task automatic t_sticky();
    w(IDX_CONFIG_3, 8'h01);
    ool_one <= 7'h40;
    cyc(3);
    chk(oe_one, 1);
    ool_one <= 7'h00;
    cyc(3);
    chk(oe_one, 1);
    rc(IDX_STATUS_ONE, 8'h40);
    cyc(1);
    chk(oe_one, 0);
    ool_one <= 7'h04;
    cyc(2);
    rc(IDX_STATUS_ONE, 8'h04);
    rc(IDX_STATUS_ONE, 8'h04);
    ool_one <= 7'h00;
    rc(IDX_STATUS_ONE, 8'h04);
    rc(IDX_STATUS_ONE, 0);
    $display("test sticky done");
  endtask

  task automatic t_mask();
    w(IDX_MASK_ONE, 8'h40);
    ool_one <= 7'h40;
    cyc(3);
    chk(oe_one, 0);
    ool_one <= 7'h00;
    rc(IDX_STATUS_ONE, 8'h40);
    w(IDX_MASK_ONE, 8'h80);
    ool_two <= 8'h80;
    cyc(3);
    chk(oe_one, 0);
    w(IDX_MASK_ONE, 0);
    cyc(2);
    chk(oe_one, 1);
    w(IDX_CONFIG_4, 8'h01);
    w(IDX_CONFIG_3, 0);
    cyc(2);
    chk({oe_one, oe_two}, 1);
    ool_two <= 8'h00;
    rc(IDX_STATUS_ONE, 8'h80);
    rc(IDX_STATUS_TWO, 8'h80);
    rc(IDX_STATUS_ONE, 0);
    chk(oe_two, 0);
    w(IDX_CONFIG_4, 0);
    $display("test mask done");
  endtask

  // host services an alert: read, mask, poll until clear, then unmask
  task automatic t_service();
    w(IDX_CONFIG_3, 8'h01);
    ool_one <= 7'h10;
    cyc(3);
    chk(oe_one, 1);
    rc(IDX_STATUS_ONE, 8'h10);
    w(IDX_MASK_ONE, 8'h10);
    cyc(1);
    chk(oe_one, 0);
    ool_one <= 7'h00;
    rc(IDX_STATUS_ONE, 8'h10);
    rc(IDX_STATUS_ONE, 0);
    w(IDX_MASK_ONE, 0);
    cyc(2);
    chk(oe_one, 0);
    $display("test service done");
  endtask

  task automatic t_timer();
    w(IDX_CONFIG_3, 8'h01);
    hot_n <= 1'b0;
    cyc(5);
    hot_n <= 1'b1;
    rc(IDX_TIMER, 0);
    w(IDX_LIMIT, 8'h01);
    w(IDX_CONFIG_3, 8'h07);
    hot_n <= 1'b0;
    cyc(4);
    chk(fan_full, 1);
    hot_n <= 1'b1;
    cyc(4);
    chk({fan_full, oe_one}, 0);
    rc(IDX_TIMER, 8'h01);
    repeat (2) begin
      hot_n <= 1'b0;
      cyc(10);
      hot_n <= 1'b1;
      cyc(5);
    end
    chk(oe_one, 1);
    rc(IDX_TIMER, 8'h02);
    rc(IDX_STATUS_TWO, 8'h20);
    rc(IDX_STATUS_TWO, 0);
    w(IDX_LIMIT, 0);
    w(IDX_MASK_TWO, 8'h20);
    hot_n <= 1'b0;
    cyc(5);
    chk(oe_one, 0);
    rc(IDX_TIMER, 8'h01);
    rc(IDX_TIMER, 8'h01);
    hot_n <= 1'b1;
    rc(IDX_STATUS_TWO, 8'h20);
    rc(IDX_TIMER, 8'h01);
    rc(IDX_STATUS_TWO, 8'h20);
    rc(IDX_STATUS_TWO, 0);
    w(IDX_LIMIT, 8'hFF);
    hot_n <= 1'b0;
    cyc(2200);
    hot_n <= 1'b1;
    cyc(3);
    rc(IDX_TIMER, 8'hFF);
    rc(IDX_TIMER, 0);
    $display("test timer done");
  endtask

  initial begin
    arst_n_in = 1'b0;
    hot_n     = 1'b1;
    ool_one   = 7'h00;
    ool_two   = 8'h00;
    repeat (5) @(posedge clk_in);
    arst_n_in <= 1'b1;
    cyc(2);
    t_regs();
    t_sticky();
    t_mask();
    t_service();
    t_timer();
    finish_test();
  end
endmodule // alert_mask_and_thermal_timer_bench
